// file: rtl/hdd_pkg.sv
// Constants for the housekeeping delay and debounce block
package hdd_pkg;
  // Register indexes
  localparam logic [7:0] HDD_OFS_PON_CFG  = 8'h0E;
  localparam logic [7:0] HDD_OFS_FLT_CFG  = 8'h0F;
  localparam logic [7:0] HDD_OFS_WARN_CFG = 8'h10;
  // Reset values
  localparam logic [7:0] HDD_PON_RST  = 8'h00;
  localparam logic [7:0] HDD_FLT_RST  = 8'h00;
  localparam logic [7:0] HDD_WARN_RST = 8'h00;
  // Field positions, power_on_pin_config
  localparam int HDD_ON_DLY_LSB  = 0;
  localparam int HDD_PIN_FN_LSB  = 2;
  localparam int HDD_REQ_INV_BIT = 5;
  // Field positions, filter_debounce_config
  localparam int HDD_DEB_LSB     = 0;
  localparam int HDD_FILT_LSB    = 2;
  localparam int HDD_GOOD_FN_LSB = 5;
  // Field positions, off_warning_config
  localparam int HDD_GOOD_INV_BIT = 0;
  localparam int HDD_GOOD_PCH_BIT = 1;
  localparam int HDD_PEN_INV_BIT  = 2;
  localparam int HDD_PEN_PCH_BIT  = 3;
  localparam int HDD_WARN_LSB     = 6;
  // Filter codes
  localparam logic [2:0] HDD_FILT_OV_A = 3'h2;
  localparam logic [2:0] HDD_FILT_OV_B = 3'h4;
  localparam logic [2:0] HDD_FILT_UV_A = 3'h3;
  localparam logic [2:0] HDD_FILT_UV_B = 3'h5;
  // Clock and tick timing
  localparam int HDD_CLK_NS  = 40;
  localparam int HDD_US_NS   = 1000;
  localparam int HDD_MS_NS   = 1000000;
  localparam int HDD_US_CYC  = HDD_US_NS / HDD_CLK_NS;
  localparam int HDD_MS_CYC  = HDD_MS_NS / HDD_CLK_NS;
  // Interval lengths in ticks
  localparam logic [10:0] HDD_DEB_80_MS   = 11'h050;
  localparam logic [10:0] HDD_DEB_40_MS   = 11'h028;
  localparam logic [10:0] HDD_DEB_160_MS  = 11'h0A0;
  localparam logic [10:0] HDD_ON_400_MS   = 11'h190;
  localparam logic [10:0] HDD_ON_200_MS   = 11'h0C8;
  localparam logic [10:0] HDD_ON_800_MS   = 11'h320;
  localparam logic [10:0] HDD_ON_1600_MS  = 11'h640;
  localparam logic [10:0] HDD_WARN_2_MS   = 11'h002;
  localparam logic [10:0] HDD_WARN_1_MS   = 11'h001;
  localparam logic [10:0] HDD_WARN_4_MS   = 11'h004;
  localparam logic [10:0] HDD_OV_FILT_US  = 11'h00F;
  localparam logic [10:0] HDD_UV_FILT_US  = 11'h1C2;
  localparam logic [10:0] HDD_ZERO        = 11'h000;
  // Address pin level codes
  localparam logic [1:0] HDD_ADDR_LOW   = 2'h0;
  localparam logic [1:0] HDD_ADDR_FLOAT = 2'h1;
  localparam logic [1:0] HDD_ADDR_HIGH  = 2'h2;
endpackage

// file: rtl/hdd_qual.sv
// Qualification counter with separate rise and fall intervals
`timescale 1ns/1ps
module hdd_qual
  import hdd_pkg::*;
#(
  parameter int W = 11
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Time base
  input  wire logic         tick,
  // Condition and intervals
  input  wire logic         din,
  input  wire logic [W-1:0] len_rise,
  input  wire logic [W-1:0] len_fall,
  // Qualified level
  output logic              dout
);
  initial begin
    if (W < 11) $error("hdd_qual width too small for longest interval");
  end

  logic [W-1:0] cnt_r;   // Ticks the condition has held
  logic [W-1:0] len;     // Interval for the pending change
  logic [W-1:0] cnt_inc; // Next count

  assign len     = din ? len_rise : len_fall;
  assign cnt_inc = cnt_r + W'(1);

  // Condition must hold the full interval; a revert clears the count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      dout  <= 1'b0;
    end else if (din == dout) begin
      cnt_r <= '0;
    end else if (len == '0) begin
      dout  <= din;
    end else if (tick) begin
      if (cnt_inc >= len) begin
        dout  <= din;
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_inc;
      end
    end
  end
endmodule

// file: rtl/hdd_top.sv
// Housekeeping delay, debounce, fault filter and pin mapping
`timescale 1ns/1ps
module hdd_top
  import hdd_pkg::*;
#(
  parameter int MS_CYCLES = HDD_MS_CYC,          // Cycles per millisecond tick
  parameter int US_CYCLES = HDD_US_CYC,          // Cycles per microsecond tick
  parameter logic [6:0] ADDR_BASE = 7'h58        // Arbitrary base bus address
) (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST,
  // Register port from the serial interface
  input  wire logic       REG_WR_EN,
  input  wire logic       REG_RD_EN,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // Power-on request pin level
  input  wire logic       POWER_ON_REQUEST_IN,
  // Raw fault comparator outputs
  input  wire logic       OVERVOLTAGE_PROTECT,
  input  wire logic       UNDERVOLTAGE_PROTECT,
  // Address pin level detectors
  input  wire logic       ADDRESS_SELECT_PIN_LO,
  input  wire logic       ADDRESS_SELECT_PIN_HI,
  // Good flag pin, open drain
  output logic            OUTPUT_GOOD_FLAG_O,
  output logic            OUTPUT_GOOD_FLAG_OE_N,
  // Power enable pin, open drain
  output logic            POWER_ENABLE_OUT_O,
  output logic            POWER_ENABLE_OUT_OE_N,
  // Formed serial bus address
  output logic      [6:0] SMB_ADDR
);
  initial begin
    if (MS_CYCLES < 2 || US_CYCLES < 2) $error("hdd_top tick divider too short");
  end

  // Configuration registers
  logic [7:0] pon_cfg_r;   // power_on_pin_config
  logic [7:0] flt_cfg_r;   // filter_debounce_config
  logic [7:0] warn_cfg_r;  // off_warning_config

  // Time base
  logic [31:0] us_cnt_r;   // Microsecond divider
  logic [31:0] ms_cnt_r;   // Millisecond divider
  logic        us_tick_r;  // One-cycle microsecond enable
  logic        ms_tick_r;  // One-cycle millisecond enable

  // Decode of register accesses
  wire wr_pon  = REG_WR_EN && (REG_ADDR == HDD_OFS_PON_CFG);
  wire wr_flt  = REG_WR_EN && (REG_ADDR == HDD_OFS_FLT_CFG);
  wire wr_warn = REG_WR_EN && (REG_ADDR == HDD_OFS_WARN_CFG);
  logic [7:0] rd_mux;      // Read selection, unmapped reads zero
  assign rd_mux = (REG_ADDR == HDD_OFS_PON_CFG)  ? pon_cfg_r  :
                  (REG_ADDR == HDD_OFS_FLT_CFG)  ? flt_cfg_r  :
                  (REG_ADDR == HDD_OFS_WARN_CFG) ? warn_cfg_r : 8'h00;

  // Field extraction
  wire [1:0] on_dly_sel = pon_cfg_r[HDD_ON_DLY_LSB +: 2];
  wire [2:0] pin_fn     = pon_cfg_r[HDD_PIN_FN_LSB +: 3];
  wire       req_inv    = pon_cfg_r[HDD_REQ_INV_BIT];
  wire [1:0] deb_sel    = flt_cfg_r[HDD_DEB_LSB +: 2];
  wire [2:0] filt_sel   = flt_cfg_r[HDD_FILT_LSB +: 3];
  wire [2:0] good_fn    = flt_cfg_r[HDD_GOOD_FN_LSB +: 3];
  wire       good_inv   = warn_cfg_r[HDD_GOOD_INV_BIT];
  wire       good_pch   = warn_cfg_r[HDD_GOOD_PCH_BIT];
  wire       pen_inv    = warn_cfg_r[HDD_PEN_INV_BIT];
  wire       pen_pch    = warn_cfg_r[HDD_PEN_PCH_BIT];
  wire [1:0] warn_sel   = warn_cfg_r[HDD_WARN_LSB +: 2];

  // Map a two-bit code onto four intervals
  function automatic logic [10:0] pick4(input logic [1:0] sel,
                                        input logic [10:0] c0, input logic [10:0] c1,
                                        input logic [10:0] c2, input logic [10:0] c3);
    unique case (sel)
      2'h0: pick4 = c0;
      2'h1: pick4 = c1;
      2'h2: pick4 = c2;
      2'h3: pick4 = c3;
    endcase
  endfunction

  // Interval lengths from the configuration
  wire [10:0] deb_len  = pick4(deb_sel, HDD_DEB_80_MS, HDD_ZERO,
                               HDD_DEB_40_MS, HDD_DEB_160_MS);
  wire [10:0] on_len   = pick4(on_dly_sel, HDD_ON_400_MS, HDD_ON_200_MS,
                               HDD_ON_800_MS, HDD_ON_1600_MS);
  wire [10:0] warn_len = pick4(warn_sel, HDD_WARN_2_MS, HDD_ZERO,
                               HDD_WARN_1_MS, HDD_WARN_4_MS);
  wire        ov_filt  = (filt_sel == HDD_FILT_OV_A) || (filt_sel == HDD_FILT_OV_B);
  wire        uv_filt  = (filt_sel == HDD_FILT_UV_A) || (filt_sel == HDD_FILT_UV_B);
  wire [10:0] ov_len   = ov_filt ? HDD_OV_FILT_US : HDD_ZERO;
  wire [10:0] uv_len   = uv_filt ? HDD_UV_FILT_US : HDD_ZERO;

  // Pin to logical meaning: asserted follows the name
  wire req_pin_in = POWER_ON_REQUEST_IN ^ req_inv;
  // Outside the input function the request pin is ignored and power stays on
  wire req_raw    = (pin_fn[2:1] == 2'b00) ? req_pin_in : 1'b1;

  // Qualified internal signals
  logic req_q;      // Debounced power-on request
  logic ov_q;       // Filtered overvoltage
  logic uv_q;       // Filtered undervoltage
  logic pen_q;      // Power enable, falls after the warning lead
  logic good_q;     // Delayed good status
  wire  fault    = ov_q | uv_q;
  wire  run_req  = req_q & ~fault;
  wire  good_in  = run_req & pen_q;

  // Register writes
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pon_cfg_r  <= HDD_PON_RST;
      flt_cfg_r  <= HDD_FLT_RST;
      warn_cfg_r <= HDD_WARN_RST;
    end else begin
      if (wr_pon)  pon_cfg_r  <= REG_WDATA;
      if (wr_flt)  flt_cfg_r  <= REG_WDATA;
      if (wr_warn) warn_cfg_r <= REG_WDATA;
    end
  end

  // Registered read data, updated on each read strobe
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD_EN) begin
      REG_RDATA <= rd_mux;
    end
  end

  // Tick dividers; one-cycle enables keep a single clock domain
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      us_cnt_r  <= '0;
      ms_cnt_r  <= '0;
      us_tick_r <= 1'b0;
      ms_tick_r <= 1'b0;
    end else begin
      us_tick_r <= (us_cnt_r == 32'(US_CYCLES - 1));
      ms_tick_r <= (ms_cnt_r == 32'(MS_CYCLES - 1));
      us_cnt_r  <= (us_cnt_r == 32'(US_CYCLES - 1)) ? '0 : us_cnt_r + 32'h0000_0001;
      ms_cnt_r  <= (ms_cnt_r == 32'(MS_CYCLES - 1)) ? '0 : ms_cnt_r + 32'h0000_0001;
    end
  end

  // Request debounce in both directions
  hdd_qual #(.W(11)) u_req (
    .clk      (MCLK),
    .rst      (RST),
    .tick     (ms_tick_r),
    .din      (req_raw),
    .len_rise (deb_len),
    .len_fall (deb_len),
    .dout     (req_q)
  );

  // Overvoltage: short pulses rejected, release immediate
  hdd_qual #(.W(11)) u_ov (
    .clk      (MCLK),
    .rst      (RST),
    .tick     (us_tick_r),
    .din      (OVERVOLTAGE_PROTECT),
    .len_rise (ov_len),
    .len_fall (HDD_ZERO),
    .dout     (ov_q)
  );

  // Undervoltage noise filter
  hdd_qual #(.W(11)) u_uv (
    .clk      (MCLK),
    .rst      (RST),
    .tick     (us_tick_r),
    .din      (UNDERVOLTAGE_PROTECT),
    .len_rise (uv_len),
    .len_fall (HDD_ZERO),
    .dout     (uv_q)
  );

  // Power enable holds on for the warning lead after the good flag drops
  hdd_qual #(.W(11)) u_pen (
    .clk      (MCLK),
    .rst      (RST),
    .tick     (ms_tick_r),
    .din      (run_req),
    .len_rise (HDD_ZERO),
    .len_fall (warn_len),
    .dout     (pen_q)
  );

  // Good flag rises after the on delay and falls at once
  hdd_qual #(.W(11)) u_good (
    .clk      (MCLK),
    .rst      (RST),
    .tick     (ms_tick_r),
    .din      (good_in),
    .len_rise (on_len),
    .len_fall (HDD_ZERO),
    .dout     (good_q)
  );

  // Pin drive: N channel pulls low, P channel pushes high, else released
  wire good_fn_on = (good_fn[2:1] == 2'b00);
  wire good_level = (good_fn_on & good_q) ^ good_inv;
  wire pen_level  = pen_q ^ pen_inv;

  // Address pin level: neither detector means floating
  wire [1:0] addr_code = ADDRESS_SELECT_PIN_LO ? HDD_ADDR_LOW  :
                         ADDRESS_SELECT_PIN_HI ? HDD_ADDR_HIGH : HDD_ADDR_FLOAT;

  // Output flip-flops; released pins keep their output level driven too
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      OUTPUT_GOOD_FLAG_O    <= 1'b0;
      OUTPUT_GOOD_FLAG_OE_N <= 1'b0;
      POWER_ENABLE_OUT_O    <= 1'b0;
      POWER_ENABLE_OUT_OE_N <= 1'b0;
      SMB_ADDR              <= ADDR_BASE;
    end else begin
      OUTPUT_GOOD_FLAG_O    <= good_pch;
      OUTPUT_GOOD_FLAG_OE_N <= good_pch ? ~good_level : good_level;
      POWER_ENABLE_OUT_O    <= pen_pch;
      POWER_ENABLE_OUT_OE_N <= pen_pch ? ~pen_level : pen_level;
      SMB_ADDR              <= ADDR_BASE | {5'h00, addr_code};
    end
  end
endmodule

// file: verif/hdd_host.sv
// Host side model: request driver and open-drain pin readers
`timescale 1ns/1ps
module hdd_host (
  // Logical request and its pin polarity
  input  wire logic req,
  input  wire logic req_inv,
  output logic      req_pin,
  // Open-drain pins from the device
  input  wire logic good_o,
  input  wire logic good_oe_n,
  input  wire logic pen_o,
  input  wire logic pen_oe_n,
  // Resolved pin levels seen by the consumers
  output logic      good_lvl,
  output logic      pen_lvl
);
  // Pin voltage is the logical request through the polarity choice
  assign req_pin = req ^ req_inv;
  // A released pin rests at its pull, the inverse of its driven level
  assign good_lvl = good_oe_n ? ~good_o : good_o;
  assign pen_lvl  = pen_oe_n ? ~pen_o : pen_o;
endmodule

// file: verif/hdd_monitor.sv
// Port checker for the housekeeping delay and debounce block
`timescale 1ns/1ps
module hdd_monitor
  import hdd_pkg::*;
#(
  parameter int         MS_CYCLES = HDD_MS_CYC,
  parameter int         US_CYCLES = HDD_US_CYC,
  parameter logic [6:0] ADDR_BASE = 7'h58
) (
  // Clock, reset and register port
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic       REG_WR_EN,
  input wire logic       REG_RD_EN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // Pins
  input wire logic       POWER_ON_REQUEST_IN,
  input wire logic       OVERVOLTAGE_PROTECT,
  input wire logic       UNDERVOLTAGE_PROTECT,
  input wire logic       ADDRESS_SELECT_PIN_LO,
  input wire logic       ADDRESS_SELECT_PIN_HI,
  input wire logic       OUTPUT_GOOD_FLAG_O,
  input wire logic       OUTPUT_GOOD_FLAG_OE_N,
  input wire logic       POWER_ENABLE_OUT_O,
  input wire logic       POWER_ENABLE_OUT_OE_N,
  input wire logic [6:0] SMB_ADDR
);
  logic [7:0]  on_r;      // Shadow of the on delay register
  logic [7:0]  cfg_r;     // Shadow of the pin drive register
  logic [1:0]  age_r;     // Cycles since a write, saturating
  int          pen_cnt_r; // Cycles the power enable has been on
  logic        map_w;
  logic        good_w;
  logic        pen_w;
  logic        ok_w;
  logic [1:0]  code_w;
  logic [10:0] on_w;
  assign map_w  = REG_ADDR inside {HDD_OFS_PON_CFG, HDD_OFS_FLT_CFG, HDD_OFS_WARN_CFG};
  // Logical flags undone from pin drive, valid once the config settled
  assign good_w = OUTPUT_GOOD_FLAG_OE_N ^ cfg_r[1] ^ cfg_r[0];
  assign pen_w  = POWER_ENABLE_OUT_OE_N ^ cfg_r[3] ^ cfg_r[2];
  assign ok_w   = age_r == 2'd3;
  assign code_w = ADDRESS_SELECT_PIN_LO ? HDD_ADDR_LOW :
                  ADDRESS_SELECT_PIN_HI ? HDD_ADDR_HIGH : HDD_ADDR_FLOAT;
  assign on_w   = on_r[1] ? (on_r[0] ? HDD_ON_1600_MS : HDD_ON_800_MS) :
                            (on_r[0] ? HDD_ON_200_MS : HDD_ON_400_MS);
  // Shadow registers and counters
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      on_r      <= 8'h00;
      cfg_r     <= 8'h00;
      age_r     <= 2'd3;
      pen_cnt_r <= 0;
    end else begin
      if (REG_WR_EN && REG_ADDR == HDD_OFS_PON_CFG) on_r <= REG_WDATA;
      if (REG_WR_EN && REG_ADDR == HDD_OFS_WARN_CFG) cfg_r <= REG_WDATA;
      age_r     <= REG_WR_EN ? 2'd0 : (ok_w ? age_r : age_r + 2'd1);
      // Saturates at the longest on delay so real divider values still fit
      pen_cnt_r <= !pen_w ? 0 :
                   (pen_cnt_r < int'(HDD_ON_1600_MS) * MS_CYCLES ? pen_cnt_r + 1 : pen_cnt_r);
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  AST_RD_UNMAPPED: assert property (REG_RD_EN && !map_w |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!REG_RD_EN |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  AST_WR_RD: assert property (REG_WR_EN && map_w ##1 REG_RD_EN && $stable(REG_ADDR)
    |=> REG_RDATA == $past(REG_WDATA, 2)) else $error("read back differs");
  AST_SMB_ADDR: assert property (1'b1 |=> SMB_ADDR == (ADDR_BASE | {5'h00, $past(code_w)}))
    else $error("bus address wrong");
  AST_GOOD_PCH: assert property (ok_w |-> OUTPUT_GOOD_FLAG_O == cfg_r[1])
    else $error("good drive type wrong");
  AST_PEN_PCH: assert property (ok_w |-> POWER_ENABLE_OUT_O == cfg_r[3])
    else $error("enable drive type wrong");
  AST_GOOD_NEEDS_PEN: assert property (ok_w && good_w |-> pen_w)
    else $error("good flag without power enable");
  AST_WARN_HOLD: assert property (ok_w && $fell(good_w) && cfg_r[7:6] == 2'b00 |-> pen_w [*8])
    else $error("power enable dropped before lead");
  AST_ON_DELAY: assert property (ok_w && $rose(good_w) |->
    pen_cnt_r >= (int'(on_w) - 1) * MS_CYCLES)
    else $error("good flag rose early");
  // Main scenarios reached
  cover property (ok_w && $rose(good_w));
  cover property (ok_w && $fell(good_w));
  cover property (REG_RD_EN && !map_w);
endmodule
bind hdd_top hdd_monitor #(.MS_CYCLES(MS_CYCLES), .US_CYCLES(US_CYCLES), .ADDR_BASE(ADDR_BASE))
  u_hdd_monitor (.*);

// file: verif/tb.sv
// Self-checking bench for the housekeeping block
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] a, d, e; logic lo, hi; logic [1:0] c;} hdd_row_t;
  localparam logic [6:0] BASE = 7'h58;
  logic mclk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, lo = 1'b0, hi = 1'b0;
  logic ov = 1'b0, uv = 1'b0, req = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  logic [6:0] smb;
  logic good_o, good_oe_n, pen_o, pen_oe_n, req_pin, good_lvl, pen_lvl;
  wire [1:0] lvl = {pen_lvl, good_lvl};
  int err_count = 0, checks = 0, n;
  // Register rows: address, data, expected read, address pin, level code
  hdd_row_t rows[5] = '{'{8'h0E, 8'h3C, 8'h3C, 1'b1, 1'b0, 2'h0},
    '{8'h0F, 8'h01, 8'h01, 1'b0, 1'b0, 2'h1}, '{8'h10, 8'h0E, 8'h0E, 1'b0, 1'b1, 2'h2},
    '{8'h11, 8'hFF, 8'h00, 1'b1, 1'b1, 2'h0}, '{8'h0D, 8'hA5, 8'h00, 1'b0, 1'b0, 2'h1}};
  always #20 mclk = ~mclk;
  hdd_top #(.MS_CYCLES(10), .US_CYCLES(4), .ADDR_BASE(BASE)) u_hdd_top (.MCLK(mclk), .RST(rst),
    .REG_WR_EN(wr_en), .REG_RD_EN(rd_en), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .POWER_ON_REQUEST_IN(req_pin), .OVERVOLTAGE_PROTECT(ov), .UNDERVOLTAGE_PROTECT(uv),
    .ADDRESS_SELECT_PIN_LO(lo), .ADDRESS_SELECT_PIN_HI(hi), .OUTPUT_GOOD_FLAG_O(good_o),
    .OUTPUT_GOOD_FLAG_OE_N(good_oe_n), .POWER_ENABLE_OUT_O(pen_o),
    .POWER_ENABLE_OUT_OE_N(pen_oe_n), .SMB_ADDR(smb));
  hdd_host u_hdd_host (.req(req), .req_inv(1'b0), .req_pin(req_pin), .good_o(good_o),
    .good_oe_n(good_oe_n), .pen_o(pen_o), .pen_oe_n(pen_oe_n), .good_lvl(good_lvl),
    .pen_lvl(pen_lvl));
  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Count lies in a window; the bound absorbs the partial first tick
  task automatic rng(input int c, input int lo_b, input int hi_b);
    check({7'h00, c >= lo_b && c <= hi_b}, 8'h01);
  endtask
  // One-cycle strobes, then an idle edge so strobes never retoggle in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask
  // Bounded wait for a pin level; running out is a failure
  task automatic wait_lvl(input int k, input logic want, input int lim, output int c);
    c = 0;
    while (lvl[k] !== want && c < lim) begin
      @(posedge mclk);
      c++;
    end
    if (lvl[k] !== want) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (rows[i]) begin
      lo <= rows[i].lo;
      hi <= rows[i].hi;
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      check(v, rows[i].e);
      check({1'b0, smb}, {1'b0, BASE | {5'h00, rows[i].c}});
    end
    // Second reset restores off_warning_config, read back as zero
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(8'h10, v);
    check(v, 8'h00);
    // Short request pulse must restart the 40 ms debounce
    wr(8'h0F, 8'h02);
    // Write then read of one register on back-to-back edges
    wr_en <= 1'b1;
    addr  <= 8'h0E;
    wdata <= 8'h01;
    @(posedge mclk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
    check(rdata, 8'h01);
    req <= 1'b1;
    repeat (300) @(posedge mclk);
    req <= 1'b0;
    @(posedge mclk);
    req <= 1'b1;
    wait_lvl(0, 1'b1, 3000, n);
    rng(n, 2375, 2415);
    // Overvoltage filter: a 2 us glitch is ignored, a held fault is not
    wr(8'h0F, 8'h0A);
    ov <= 1'b1;
    repeat (8) @(posedge mclk);
    ov <= 1'b0;
    repeat (20) @(posedge mclk);
    check({7'h00, good_lvl}, 8'h01);
    ov <= 1'b1;
    wait_lvl(0, 1'b0, 200, n);
    rng(n, 20, 104);
    wait_lvl(1, 1'b0, 100, n);
    rng(n, 8, 25);
    ov <= 1'b0;
    wait_lvl(0, 1'b1, 2600, n);
    // Undervoltage filter interval stays within 600 us
    wr(8'h0F, 8'h0E);
    uv <= 1'b1;
    wait_lvl(0, 1'b0, 2600, n);
    rng(n, (int'(hdd_pkg::HDD_UV_FILT_US) - 1) * 4, 2404);
    uv <= 1'b0;
    wait_lvl(0, 1'b1, 2600, n);
    // No debounce and no early warning: both pins drop together
    wr(8'h0F, 8'h01);
    wr(8'h10, 8'h40);
    req <= 1'b0;
    wait_lvl(0, 1'b0, 100, n);
    rng(n, 2, 6);
    check({7'h00, pen_lvl}, 8'h00);
    // Longest on delay, counted from the undebounced request
    wr(8'h0E, 8'h03);
    req <= 1'b1;
    wait_lvl(0, 1'b1, 17000, n);
    rng(n, 15990, 16010);
    // Inverted good pin, then good pin given another function
    // Pins follow a write one edge after the register takes it
    wr(8'h10, 8'h01);
    @(posedge mclk);
    check({7'h00, good_lvl}, 8'h00);
    wr(8'h0F, 8'h42);
    @(posedge mclk);
    check({7'h00, good_lvl}, 8'h01);
    // Request pin off its input function: a dropped pin is ignored
    // Wait outlasts the 40 ms debounce plus the warning lead
    wr(8'h0E, 8'h09);
    req <= 1'b0;
    repeat (600) @(posedge mclk);
    check({7'h00, pen_lvl}, 8'h01);
    // P-channel drive on both pins, power enable inverted
    wr(8'h10, 8'h0E);
    @(posedge mclk);
    check({7'h00, pen_o}, 8'h01);
    check({7'h00, good_o}, 8'h01);
    check({7'h00, pen_lvl}, 8'h00);
    check({7'h00, good_lvl}, 8'h00);
    tally_and_finish();
  end
endmodule
